// File: iru_pkg.sv
// Constants and types shared by the interrupt and reset sequencer
package iru_pkg;

  // ********************************************************
  // Vector addresses and stack page
  // ********************************************************
  localparam logic [15:0] VEC_NMI_LO = 16'hfffa;
  localparam logic [15:0] VEC_NMI_HI = 16'hfffb;
  localparam logic [15:0] VEC_RST_LO = 16'hfffc;
  localparam logic [15:0] VEC_RST_HI = 16'hfffd;
  localparam logic [15:0] VEC_IRQ_LO = 16'hfffe;
  localparam logic [15:0] VEC_IRQ_HI = 16'hffff;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] ZERO_PAGE = 8'h00;

  // ********************************************************
  // Reset values and status bit positions
  // ********************************************************
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'hfd;
  localparam logic [7:0] P_RESET = 8'h20;
  localparam logic [1:0] SYNC_IDLE = 2'h3;
  localparam int P_I = 2;
  localparam int P_B = 4;
  localparam int P_U = 5;
  localparam int P_V = 6;

  // ********************************************************
  // Timing counts, in processor cycles of two clocks each
  // ********************************************************
  localparam int INIT_CYCLES = 6;
  localparam logic [2:0] INIT_LAST = 3'(INIT_CYCLES - 1);

  // ********************************************************
  // Sequencer states and addressing modes
  // ********************************************************
  typedef enum logic [3:0] {
    ST_RST = 4'h0, ST_INIT = 4'h1, ST_VECL = 4'h2, ST_VECH = 4'h3,
    ST_FETCH = 4'h4, ST_OPR1 = 4'h5, ST_OPR2 = 4'h6, ST_DATA = 4'h7,
    ST_PUSHH = 4'h8, ST_PUSHL = 4'h9, ST_PUSHP = 4'ha,
    ST_IVECL = 4'hb, ST_IVECH = 4'hc
  } iru_state_type;

  typedef enum logic [3:0] {
    MD_IMPL = 4'h0, MD_ACC = 4'h1, MD_IMM = 4'h2, MD_ZP = 4'h3,
    MD_ZPX = 4'h4, MD_ZPY = 4'h5, MD_ABS = 4'h6, MD_ABSX = 4'h7,
    MD_ABSY = 4'h8, MD_REL = 4'h9
  } iru_mode_type;

  typedef struct packed {
    iru_state_type st;
    iru_mode_type mode;
    logic ph;
    logic [2:0] cnt;
    logic [15:0] pc;
    logic [7:0] sp;
    logic [7:0] p;
    logic [7:0] b2;
    logic wr;
    logic taken;
    logic vnmi;
    logic npend;
    logic ilvl;
    logic nprev;
    logic sprev;
    logic [1:0] rdy_q;
    logic [1:0] irq_q;
    logic [1:0] nmi_q;
    logic [1:0] so_q;
    logic [15:0] addr;
    logic rw;
    logic sync;
    logic [7:0] dout;
    logic doe;
    logic phi1;
    logic phi2;
    logic [7:0] opc;
    logic opv;
    logic [7:0] rdat;
    logic rdv;
  } iru_reg_type;

endpackage : iru_pkg

// File: iru_ea_if.sv
// Interface between the sequencer and its address calculator
`timescale 1ns/1ns
interface iru_ea_if;
  iru_pkg::iru_mode_type mode;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [7:0] x;
  logic [7:0] y;
  logic [15:0] pc_nxt;
  logic [15:0] ea;
  logic [15:0] target;
  modport calc (input mode, lo, hi, x, y, pc_nxt, output ea, target);
  modport user (output mode, lo, hi, x, y, pc_nxt, input ea, target);
endinterface : iru_ea_if

// File: iru_ea.sv
// Effective address and branch target calculator
`timescale 1ns/1ns
module iru_ea (
  // Operands in, addresses out
  iru_ea_if.calc eab
);

  logic [7:0] idx;

  // ********************************************************
  // Index selection
  // ********************************************************
  // Non-indexed modes add zero so each sum serves plain and indexed modes
  always_comb begin
    case (eab.mode)
      iru_pkg::MD_ZPX, iru_pkg::MD_ABSX: idx = eab.x;
      iru_pkg::MD_ZPY, iru_pkg::MD_ABSY: idx = eab.y;
      default: idx = 8'h00;
    endcase
  end

  // ********************************************************
  // Address forming
  // ********************************************************
  // Eight-bit sum on page zero, so the carry is lost on purpose
  always_comb begin
    case (eab.mode)
      iru_pkg::MD_ZP, iru_pkg::MD_ZPX, iru_pkg::MD_ZPY: begin
        eab.ea = {iru_pkg::ZERO_PAGE, 8'(eab.lo + idx)};
      end
      default: begin
        eab.ea = {eab.hi, eab.lo} + {8'h00, idx};
      end
    endcase
  end

  // Signed offset from the address of the next instruction
  assign eab.target = eab.pc_nxt + {{8{eab.lo[7]}}, eab.lo};

endmodule : iru_ea

// File: iru_seq.sv
// Bus sequencer for interrupt, reset and operand address handling
//
// How it works
// - Finish current instruction, then check mask flag
// - Unmasked request pushes program counter and status
// - Set mask flag after state is saved
// - Maskable vector read from fffe then ffff
// - No interrupt recognised while ready is low
// - Non-maskable input acts on falling edge only
// - Non-maskable request ignores the mask flag
// - Non-maskable vector read from fffa then fffb
// - Sample requests in phase two, enter phase one
// - Set-overflow falling edge, sampled ending phase one
// - Opcode fetch flag high through fetch cycle only
// - Ready low at fetch freezes until ready high
// - No bus writes while reset is held low
// - Six init cycles, set mask, vector fffc/fffd
// - Direction high for reads, low for writes
// - Immediate operand is second byte, no access
// - Absolute address is byte three, byte two
// - Zero page forces high address byte zero
// - Zero page index sum wraps within page
// - Absolute indexed adds index to sixteen bits
// - Branch adds signed offset to next address
// - Ready low during write does not halt
// - Ready low on read holds current address, except in init
`timescale 1ns/1ns
module iru_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Memory bus
  output logic [15:0] addr,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] data_in,
  output logic rw,
  output logic opfetch,
  output logic phi1_out,
  output logic phi2_out,
  // Asynchronous control pins
  input wire logic rdy,
  input wire logic irq_n,
  input wire logic nmi_n,
  input wire logic so_n,
  // Instruction core side
  output logic [7:0] opcode,
  output logic opcode_valid,
  output logic [7:0] operand,
  output logic operand_valid,
  output logic [7:0] status,
  input wire logic [3:0] dec_mode,
  input wire logic dec_write,
  input wire logic dec_taken,
  input wire logic [7:0] idx_x,
  input wire logic [7:0] idx_y,
  input wire logic [7:0] wr_data,
  input wire logic p_we,
  input wire logic [7:0] p_wdata
);

  // ********************************************************
  // State, reset value and address calculator
  // ********************************************************
  // Reads high and drives nothing from the first reset edge
  localparam iru_pkg::iru_reg_type RST_VAL = '{
    st: iru_pkg::ST_RST, mode: iru_pkg::MD_IMPL,
    pc: iru_pkg::ADDR_RESET, addr: iru_pkg::ADDR_RESET,
    sp: iru_pkg::SP_RESET, p: iru_pkg::P_RESET,
    rdy_q: iru_pkg::SYNC_IDLE, irq_q: iru_pkg::SYNC_IDLE,
    nmi_q: iru_pkg::SYNC_IDLE, so_q: iru_pkg::SYNC_IDLE,
    rw: 1'b1, phi1: 1'b1, nprev: 1'b1, sprev: 1'b1, default: '0};

  iru_pkg::iru_reg_type s_r;
  iru_pkg::iru_reg_type n;
  logic done_c;
  logic go_int;

  iru_ea_if ea_bus();

  // The final operand byte comes straight off the bus to save a cycle
  assign ea_bus.mode = s_r.mode;
  assign ea_bus.lo = (s_r.st == iru_pkg::ST_OPR1) ? data_in : s_r.b2;
  assign ea_bus.hi = data_in;
  assign ea_bus.x = idx_x;
  assign ea_bus.y = idx_y;
  assign ea_bus.pc_nxt = s_r.pc + 16'h0001;

  iru_ea u_ea (
    .eab (ea_bus.calc)
  );

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    n = s_r;
    done_c = 1'b0;
    // NMI wins over IRQ; IRQ only with the mask clear
    go_int = s_r.npend || (s_r.ilvl && !s_r.p[iru_pkg::P_I]);
    n.opv = 1'b0;
    n.rdv = 1'b0;
    // Two-flop synchronisers; only stage two is read by logic
    n.rdy_q = {s_r.rdy_q[0], rdy};
    n.irq_q = {s_r.irq_q[0], irq_n};
    n.nmi_q = {s_r.nmi_q[0], nmi_n};
    n.so_q = {s_r.so_q[0], so_n};
    // Phase toggles every clock: ph low is phase one
    n.ph = ~s_r.ph;
    n.phi1 = s_r.ph;
    n.phi2 = ~s_r.ph;
    // Core decode is taken at the end of phase one
    if (!s_r.ph && s_r.st == iru_pkg::ST_OPR1) begin
      n.mode = iru_pkg::iru_mode_type'(dec_mode);
      n.wr = dec_write;
      n.taken = dec_taken;
    end
    // Core flag writes land at the end of phase two
    if (s_r.ph && p_we) begin
      n.p = p_wdata;
      n.p[iru_pkg::P_U] = 1'b1;
    end
    // Overflow set after core write, so the edge is never lost
    if (!s_r.ph) begin
      n.sprev = s_r.so_q[1];
      if (s_r.sprev && !s_r.so_q[1]) begin
        n.p[iru_pkg::P_V] = 1'b1;
      end
    end
    if (s_r.st == iru_pkg::ST_RST) begin
      // First edge with reset released starts the init count
      n.st = iru_pkg::ST_INIT;
      n.ph = 1'b0;
      n.phi1 = 1'b1;
      n.phi2 = 1'b0;
      n.cnt = 3'h0;
    end else if (s_r.ph && (!s_r.rw || s_r.rdy_q[1] ||
                 s_r.st == iru_pkg::ST_INIT)) begin
      // A bus cycle ends; a read with ready low repeats instead, except in init
      case (s_r.st)
        iru_pkg::ST_INIT: begin
          if (s_r.cnt == iru_pkg::INIT_LAST) begin
            n.st = iru_pkg::ST_VECL;
            n.p[iru_pkg::P_I] = 1'b1;
          end else begin
            n.cnt = s_r.cnt + 3'h1;
          end
        end
        iru_pkg::ST_VECL: begin
          n.b2 = data_in;
          n.st = iru_pkg::ST_VECH;
        end
        iru_pkg::ST_VECH: begin
          n.pc = {data_in, s_r.b2};
          done_c = 1'b1;
        end
        iru_pkg::ST_FETCH: begin
          n.opc = data_in;
          n.opv = 1'b1;
          n.pc = s_r.pc + 16'h0001;
          n.st = iru_pkg::ST_OPR1;
        end
        iru_pkg::ST_OPR1: begin
          case (s_r.mode)
            iru_pkg::MD_IMM: begin
              // Second byte is the operand itself
              n.rdat = data_in;
              n.rdv = 1'b1;
              n.pc = s_r.pc + 16'h0001;
              done_c = 1'b1;
            end
            iru_pkg::MD_ZP, iru_pkg::MD_ZPX, iru_pkg::MD_ZPY: begin
              n.pc = s_r.pc + 16'h0001;
              n.addr = ea_bus.ea;
              n.st = iru_pkg::ST_DATA;
            end
            iru_pkg::MD_ABS, iru_pkg::MD_ABSX, iru_pkg::MD_ABSY: begin
              n.b2 = data_in;
              n.pc = s_r.pc + 16'h0001;
              n.st = iru_pkg::ST_OPR2;
            end
            iru_pkg::MD_REL: begin
              // Offset counts from the already advanced counter
              n.pc = s_r.taken ? ea_bus.target : ea_bus.pc_nxt;
              done_c = 1'b1;
            end
            default: begin
              // Implied and accumulator: read is a dummy
              done_c = 1'b1;
            end
          endcase
        end
        iru_pkg::ST_OPR2: begin
          n.pc = s_r.pc + 16'h0001;
          n.addr = ea_bus.ea;
          n.st = iru_pkg::ST_DATA;
        end
        iru_pkg::ST_DATA: begin
          if (!s_r.wr) begin
            n.rdat = data_in;
            n.rdv = 1'b1;
          end
          done_c = 1'b1;
        end
        iru_pkg::ST_PUSHH: begin
          n.sp = s_r.sp - 8'h01;
          n.st = iru_pkg::ST_PUSHL;
        end
        iru_pkg::ST_PUSHL: begin
          n.sp = s_r.sp - 8'h01;
          n.st = iru_pkg::ST_PUSHP;
        end
        iru_pkg::ST_PUSHP: begin
          n.sp = s_r.sp - 8'h01;
          n.p[iru_pkg::P_I] = 1'b1;
          n.st = iru_pkg::ST_IVECL;
        end
        iru_pkg::ST_IVECL: begin
          n.b2 = data_in;
          n.st = iru_pkg::ST_IVECH;
        end
        iru_pkg::ST_IVECH: begin
          n.pc = {data_in, s_r.b2};
          done_c = 1'b1;
        end
        default: begin
          n.st = iru_pkg::ST_RST;
        end
      endcase
      // Instruction boundary: enter interrupt or fetch next opcode
      if (done_c) begin
        if (go_int) begin
          n.st = iru_pkg::ST_PUSHH;
          n.vnmi = s_r.npend;
          n.npend = 1'b0;
        end else begin
          n.st = iru_pkg::ST_FETCH;
        end
      end
      // Bus outputs for the cycle about to start
      n.sync = (n.st == iru_pkg::ST_FETCH);
      n.rw = 1'b1;
      n.doe = 1'b0;
      case (n.st)
        iru_pkg::ST_FETCH, iru_pkg::ST_OPR1, iru_pkg::ST_OPR2: begin
          n.addr = n.pc;
        end
        iru_pkg::ST_VECL: n.addr = iru_pkg::VEC_RST_LO;
        iru_pkg::ST_VECH: n.addr = iru_pkg::VEC_RST_HI;
        iru_pkg::ST_IVECL: begin
          n.addr = n.vnmi ? iru_pkg::VEC_NMI_LO
                          : iru_pkg::VEC_IRQ_LO;
        end
        iru_pkg::ST_IVECH: begin
          n.addr = n.vnmi ? iru_pkg::VEC_NMI_HI
                          : iru_pkg::VEC_IRQ_HI;
        end
        iru_pkg::ST_PUSHH: begin
          n.addr = {iru_pkg::STACK_PAGE, n.sp};
          n.dout = n.pc[15:8];
          n.rw = 1'b0;
          n.doe = 1'b1;
        end
        iru_pkg::ST_PUSHL: begin
          n.addr = {iru_pkg::STACK_PAGE, n.sp};
          n.dout = n.pc[7:0];
          n.rw = 1'b0;
          n.doe = 1'b1;
        end
        iru_pkg::ST_PUSHP: begin
          // Hardware entry pushes the break bit clear
          n.addr = {iru_pkg::STACK_PAGE, n.sp};
          n.dout = n.p;
          n.dout[iru_pkg::P_B] = 1'b0;
          n.rw = 1'b0;
          n.doe = 1'b1;
        end
        iru_pkg::ST_DATA: begin
          n.rw = !n.wr;
          n.doe = n.wr;
          n.dout = wr_data;
        end
        default: n.addr = s_r.addr;
      endcase
    end
    // Requests sampled in phase two, only while ready is high
    if (s_r.ph && s_r.rdy_q[1]) begin
      n.nprev = s_r.nmi_q[1];
      n.ilvl = !s_r.irq_q[1];
      if (s_r.nprev && !s_r.nmi_q[1]) begin
        n.npend = 1'b1;
      end
    end
  end

  // ********************************************************
  // State register
  // ********************************************************
  // Reset holds the bus in read with drivers off
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= RST_VAL;
    end else begin
      s_r <= n;
    end
  end

  // Outputs straight from the state register
  assign addr = s_r.addr;
  assign data_out = s_r.dout;
  assign data_oe = s_r.doe;
  assign rw = s_r.rw;
  assign opfetch = s_r.sync;
  assign phi1_out = s_r.phi1;
  assign phi2_out = s_r.phi2;
  assign opcode = s_r.opc;
  assign opcode_valid = s_r.opv;
  assign operand = s_r.rdat;
  assign operand_valid = s_r.rdv;
  assign status = s_r.p;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_rst_quiet;
    disable iff (1'b0) !reset_n |=> (s_r.rw && !s_r.doe);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("bus written during reset");

  property p_rst_seq;
    $rose(reset_n) |-> ##[12:14] (s_r.st == iru_pkg::ST_VECL &&
      s_r.addr == iru_pkg::VEC_RST_LO && s_r.p[iru_pkg::P_I]);
  endproperty
  a_rst_seq: assert property (p_rst_seq)
    else $error("reset vector not fetched after six cycles");

  property p_mask;
    (done_c && !s_r.npend && s_r.p[iru_pkg::P_I])
      |=> s_r.st == iru_pkg::ST_FETCH;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked request was taken");

  property p_take;
    (done_c && go_int) |=> (s_r.st == iru_pkg::ST_PUSHH &&
      s_r.vnmi == $past(s_r.npend));
  endproperty
  a_take: assert property (p_take)
    else $error("interrupt entry missed or wrong source");

  sequence s_push_entry;
    $rose(s_r.st == iru_pkg::ST_PUSHH);
  endsequence
  sequence s_push_walk;
    (!s_r.rw && s_r.dout == s_r.pc[15:8]) ##2
    (s_r.addr == $past(s_r.addr, 2) - 16'h0001 &&
     s_r.dout == s_r.pc[7:0]) ##2
    (s_r.addr == $past(s_r.addr, 2) - 16'h0001 &&
     !s_r.dout[iru_pkg::P_B]);
  endsequence
  property p_push;
    s_push_entry |-> s_push_walk;
  endproperty
  a_push: assert property (p_push)
    else $error("stack push order wrong");

  property p_mask_set;
    $rose(s_r.st == iru_pkg::ST_IVECL) |->
      (s_r.p[iru_pkg::P_I] && $past(s_r.st) == iru_pkg::ST_PUSHP);
  endproperty
  a_mask_set: assert property (p_mask_set)
    else $error("mask not set at vector fetch");

  property p_vec;
    (s_r.st == iru_pkg::ST_IVECL) |-> s_r.addr ==
      (s_r.vnmi ? iru_pkg::VEC_NMI_LO : iru_pkg::VEC_IRQ_LO);
  endproperty
  a_vec: assert property (p_vec)
    else $error("wrong interrupt vector");

  property p_nmi_edge;
    (s_r.ph && s_r.rdy_q[1] && s_r.nprev && !s_r.nmi_q[1])
      |=> s_r.npend;
  endproperty
  a_nmi_edge: assert property (p_nmi_edge)
    else $error("falling edge did not post request");

  property p_so;
    (!s_r.ph && s_r.sprev && !s_r.so_q[1]) |=> s_r.p[iru_pkg::P_V];
  endproperty
  a_so: assert property (p_so)
    else $error("overflow flag not set");

  property p_sync;
    $rose(s_r.sync) |-> s_r.phi1 ##1 (s_r.sync && s_r.phi2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("opcode fetch flag timing wrong");

  property p_halt;
    (s_r.ph && s_r.rw && !s_r.rdy_q[1] && s_r.st != iru_pkg::ST_INIT &&
     s_r.st != iru_pkg::ST_RST)
      |=> ($stable(s_r.addr) && $stable(s_r.st) && $stable(s_r.sync));
  endproperty
  a_halt: assert property (p_halt)
    else $error("read cycle not held with ready low");

  property p_wr_go;
    (s_r.ph && !s_r.rw) |=> s_r.st != $past(s_r.st);
  endproperty
  a_wr_go: assert property (p_wr_go)
    else $error("write cycle halted");

  property p_dir;
    s_r.rw == !s_r.doe;
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction and drive disagree");

  property p_zp;
    (s_r.st == iru_pkg::ST_DATA && (s_r.mode == iru_pkg::MD_ZP ||
     s_r.mode == iru_pkg::MD_ZPX || s_r.mode == iru_pkg::MD_ZPY))
      |-> s_r.addr[15:8] == iru_pkg::ZERO_PAGE;
  endproperty
  a_zp: assert property (p_zp)
    else $error("zero page address left page zero");

endmodule : iru_seq

// File: iru_mem.sv
// Memory model on the far side of the sequencer bus
`timescale 1ns/1ns
module iru_mem (
  // Clock
  input wire logic clk,
  // Bus from the device
  input wire logic [15:0] addr,
  input wire logic rw,
  input wire logic data_oe,
  input wire logic [7:0] data_out,
  input wire logic phi2_out,
  // Read data back
  output logic [7:0] data_in
);
  // ****
  // Storage
  // ****
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;

  // Released bus shows the inverse of the last byte, never stale data
  always_comb begin
    if (rw && !data_oe) data_in = mem[addr];
    else data_in = ~last;
  end

  // Writes land at the end of phase two; bench also fills this array
  always @(posedge clk) begin
    if (data_oe && !rw && phi2_out) mem[addr] <= data_out;
    if (rw && phi2_out) last <= mem[addr];
  end
endmodule : iru_mem

// File: tb_iru_seq.sv
// Self-checking bench for the interrupt and reset sequencer
`timescale 1ns/1ns
module tb_iru_seq;
  // ****
  // Signals
  // ****
  logic clk, reset_n, rw, opfetch, phi1_out, phi2_out, data_oe, wrc;
  logic opcode_valid, operand_valid, rdy, irq_n, nmi_n, so_n;
  logic dec_write, dec_taken, p_we;
  logic [3:0] dec_mode;
  logic [7:0] data_out, data_in, opcode, operand, status, idx_x, idx_y;
  logic [7:0] wr_data, p_wdata;
  logic [15:0] addr, fa;
  logic [15:0] pc = 16'h0340;
  logic [7:0] sp = 8'hfd;
  logic [7:0] p_exp = 8'h24;
  logic [31:0] seed = 32'd13;
  logic rdy_rand = 1'b0;
  logic watch = 1'b0;
  logic [25:0] exp_q [$];
  logic [4:0] prog [11] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0a,
                            5'h0c, 5'h0e, 5'h10, 5'h13, 5'h12};
  int err_count = 0;
  int check_count = 0;

  assign wrc = data_oe === 1'b1 && phi2_out === 1'b1;

  iru_seq iru_seq_i (.clk(clk), .reset_n(reset_n), .addr(addr),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .rw(rw),
    .opfetch(opfetch), .phi1_out(phi1_out), .phi2_out(phi2_out),
    .rdy(rdy), .irq_n(irq_n), .nmi_n(nmi_n), .so_n(so_n),
    .opcode(opcode), .opcode_valid(opcode_valid), .operand(operand),
    .operand_valid(operand_valid), .status(status),
    .dec_mode(dec_mode), .dec_write(dec_write), .dec_taken(dec_taken),
    .idx_x(idx_x), .idx_y(idx_y), .wr_data(wr_data), .p_we(p_we),
    .p_wdata(p_wdata));
  iru_mem iru_mem_i (.clk(clk), .addr(addr), .rw(rw), .data_oe(data_oe),
    .data_out(data_out), .phi2_out(phi2_out), .data_in(data_in));

  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [25:0] seen, input logic [25:0] want,
                     input string what);
    check_count++;
    if (seen !== want) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  task automatic take(input logic [25:0] seen, input string what);
    if (exp_q.size() == 0) chk(seen, '1, what);
    else chk(seen, exp_q.pop_front(), what);
  endtask : take

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // One instruction: note its results, then play the decoder at its fetch
  task automatic instr(input logic [3:0] md, input logic tk,
                       input logic [1:0] irq);
    logic [7:0] b2;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] wd;
    logic [15:0] ea;
    int n;
    x = 8'(rnd());
    y = 8'(rnd());
    wd = 8'(rnd());
    // High byte kept away from code, stack and vectors
    iru_mem_i.mem[pc + 16'd2] = 8'h40 | 8'(rnd() % 64);
    b2 = iru_mem_i.mem[pc + 16'd1];
    ea = {iru_mem_i.mem[pc + 16'd2], b2};
    if (md == 4'h3) ea = {8'h00, b2};
    if (md == 4'h4) ea = {8'h00, b2 + x};
    if (md == 4'h5) ea = {8'h00, b2 + y};
    if (md == 4'h7) ea = ea + {8'h00, x};
    if (md == 4'h8) ea = ea + {8'h00, y};
    exp_q.push_back({2'd1, pc, iru_mem_i.mem[pc]});
    if (md == 4'h2) exp_q.push_back({2'd3, 16'h0, b2});
    if (md > 4'h2 && md < 4'h9) exp_q.push_back({2'd2, ea, wd});
    pc = pc + (md < 4'h2 ? 16'd1 : md > 4'h5 && md < 4'h9 ? 16'd3 : 16'd2);
    if (md == 4'h9 && tk) pc = pc + {{8{b2[7]}}, b2};
    if (irq != 2'd0) begin
      exp_q.push_back({2'd2, 8'h01, sp, pc[15:8]});
      exp_q.push_back({2'd2, 8'h01, sp - 8'd1, pc[7:0]});
      exp_q.push_back({2'd2, 8'h01, sp - 8'd2, p_exp & 8'hef});
      sp = sp - 8'd3;
      p_exp = p_exp | 8'h04;
      ea = irq[1] ? 16'hfffa : 16'hfffe;
      pc = {iru_mem_i.mem[ea + 16'd1], iru_mem_i.mem[ea]};
    end
    @(negedge clk);
    for (n = 0; n < 300 && opcode_valid !== 1'b1; n++) @(negedge clk);
    chk(26'(n < 300), 26'd1, "fetch wait");
    dec_mode = md;
    dec_write = md > 4'h2 && md < 4'h9;
    dec_taken = tk;
    idx_x = x;
    idx_y = y;
    wr_data = wd;
    irq_n = !irq[0];
    nmi_n = nmi_n && !irq[1];
    // Level request must stay low until the first push is seen
    for (n = 0; irq[0] && n < 300 && !(wrc && addr[15:8] === 8'h01); n++)
      @(negedge clk);
    irq_n = 1'b1;
  endtask : instr

  task automatic set_status(input logic [7:0] v);
    p_wdata = v;
    p_we = 1'b1;
    repeat (2) @(negedge clk);
    p_we = 1'b0;
    p_exp = v | 8'h20;
  endtask : set_status

  // Ready pulled low in phase one must freeze a read cycle
  task automatic halt_check();
    logic [15:0] held;
    @(negedge clk iff phi1_out === 1'b1);
    rdy = 1'b0;
    repeat (8) @(negedge clk);
    held = addr;
    repeat (8) @(negedge clk);
    chk({10'h0, addr}, {10'h0, held}, "halted address");
    chk(26'(rw), 26'd1, "halted direction");
    rdy = 1'b1;
  endtask : halt_check

  // Results matched in order against the notes left by the drivers
  always @(negedge clk iff watch) begin
    if (opfetch === 1'b1) fa = addr;
    if (opcode_valid === 1'b1) take({2'd1, fa, opcode}, "fetch");
    if (wrc) take({2'd2, addr, data_out}, "write");
    if (wrc) chk(26'(rw), 26'd0, "direction");
    if (wrc) chk(26'(opfetch), 26'd0, "fetch flag");
    if (operand_valid === 1'b1) take({2'd3, 16'h0, operand}, "operand");
  end

  // Random wait states, changed only in phase one
  always @(negedge clk) begin
    if (rdy_rand && phi1_out === 1'b1) rdy <= rnd() % 4 != 0;
  end

  // Hang guard, far beyond the few hundred clocks the run needs
  initial begin
    #1000000;
    err_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    {reset_n, p_we, dec_write, dec_taken} = 4'h0;
    {rdy, irq_n, nmi_n, so_n} = 4'hf;
    {dec_mode, idx_x, idx_y, wr_data, p_wdata} = 36'h0;
    for (int a = 0; a < 4096; a++) iru_mem_i.mem[a] = 8'(rnd());
    for (int v = 0; v < 6; v++)
      iru_mem_i.mem[16'hfffa + v] = v[0] ? 8'h03 : 8'(96 - v * 16);
    // Reset held well past the two-cycle minimum
    repeat (20) begin
      @(negedge clk);
      chk({addr, 8'h00, data_oe, rw}, 26'h1, "bus in reset");
    end
    reset_n = 1'b1;
    watch = 1'b1;
    instr(4'h6, 1'b0, 2'd0);
    chk({18'h0, status}, 26'h24, "status after reset");
    $display("test reset done");
    rdy_rand = 1'b1;
    repeat (2) foreach (prog[i]) instr(prog[i][4:1], prog[i][0], 2'd0);
    rdy_rand = 1'b0;
    @(negedge clk);
    rdy = 1'b1;
    $display("test modes done");
    instr(4'h6, 1'b0, 2'd0);
    halt_check();
    set_status(8'h00);
    instr(4'h6, 1'b0, 2'd1);
    instr(4'h6, 1'b0, 2'd2);
    repeat (3) instr(4'h3, 1'b0, 2'd0);
    nmi_n = 1'b1;
    instr(4'h6, 1'b0, 2'd0);
    set_status(8'h00);
    instr(4'h6, 1'b0, 2'd3);
    instr(4'h2, 1'b0, 2'd0);
    for (int n = 0; n < 100 && exp_q.size() != 0; n++) @(negedge clk);
    chk(26'(exp_q.size()), 26'd0, "notes left");
    watch = 1'b0;
    $display("test interrupts done");
    so_n = 1'b0;
    repeat (4) @(negedge clk);
    so_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({18'h0, status}, {18'h0, p_exp | 8'h40}, "overflow");
    $display("test overflow done");
    give_verdict();
  end
endmodule : tb_iru_seq
